// ===== rtl/speculation_control_reg_pkg.sv
// constants for the guest speculation control block
`default_nettype none
package speculation_control_reg_pkg;
  localparam int unsigned SPEC_W = 32;
  localparam int unsigned FEAT_W = 64;
  localparam int unsigned ISOLATION_BIT = 7;
  localparam int unsigned SAMPLING_BLOCK_BIT = 6;
  localparam int unsigned RESTRICT_BIT = 0;
  localparam int unsigned FEATURE_ID_BIT = 20;
  localparam int unsigned CTX_W = 4;
  localparam int unsigned TABLE_DEPTH = 16;
  localparam int unsigned TABLE_AW = 4;
  // register byte offsets
  localparam logic [7:0] OFS_HOST_SPEC = 8'h00;
  localparam logic [7:0] OFS_GUEST_SPEC = 8'h04;
  localparam logic [7:0] OFS_EFFECTIVE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFS_FEATURE_ID = 8'h18;
  localparam logic [7:0] OFS_CONTEXT = 8'h1C;
  localparam logic [31:0] RESET_SPEC = 32'h0000_0000;
  localparam logic [3:0] RESET_CTX = 4'h0;
  // event bits in the interrupt status register
  localparam int unsigned EV_ENTRY = 0;
  localparam int unsigned EV_EXIT = 1;
  localparam int unsigned EV_INVALID = 2;
  localparam int unsigned EV_FLUSH = 3;
  localparam int unsigned EV_W = 4;
  typedef enum logic [1:0] {
    MODE_HOST  = 2'b00,
    MODE_GUEST = 2'b01
  } mode_e;
endpackage : speculation_control_reg_pkg
`default_nettype wire

// ===== rtl/pred_tag_mem.sv
// owner-tag memory for branch target table entries
`timescale 1ns/100ps
`default_nettype none
module pred_tag_mem (
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  input  wire logic                               wr_en,
  input  wire logic [speculation_control_reg_pkg::TABLE_AW-1:0] wr_addr,
  input  wire logic [speculation_control_reg_pkg::CTX_W-1:0]    wr_ctx,
  input  wire logic                               flush,
  input  wire logic [speculation_control_reg_pkg::TABLE_AW-1:0] rd_addr,
  output logic                                    rd_valid,
  output logic [speculation_control_reg_pkg::CTX_W-1:0]         rd_ctx
);
  logic [speculation_control_reg_pkg::TABLE_DEPTH-1:0] valid;
  logic [speculation_control_reg_pkg::TABLE_DEPTH-1:0] next_valid;
  logic [speculation_control_reg_pkg::CTX_W-1:0]       owner [speculation_control_reg_pkg::TABLE_DEPTH];
  logic                                  next_rd_valid;
  logic [speculation_control_reg_pkg::CTX_W-1:0]       next_rd_ctx;

  always_comb begin
    next_valid = valid;
    if (flush) begin
      next_valid = '0;
    end else if (wr_en) begin
      next_valid[wr_addr] = 1'b1;
    end
    next_rd_valid = valid[rd_addr];
    next_rd_ctx   = owner[rd_addr];
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      valid    <= '0;
      rd_valid <= 1'b0;
      rd_ctx   <= speculation_control_reg_pkg::RESET_CTX;
    end else begin
      valid    <= next_valid;
      rd_valid <= next_rd_valid;
      rd_ctx   <= next_rd_ctx;
    end
  end

  // tag array carries no reset; valid bits qualify it
  always_ff @(posedge clk) begin
    if (wr_en && !flush) begin
      owner[wr_addr] <= wr_ctx;
    end
  end
endmodule : pred_tag_mem
`default_nettype wire

// ===== rtl/guest_speculation_control_reg.sv
// host and guest speculation control copies with isolation and sampling checks
// Function
// RL1 - feature bit 7 enables predictor isolation
// RL2 - track entry owners, flush foreign entries
// RL3 - restrict bit set blocks table writes
// RL4 - host stub should run with restrict set
// RL5 - feature bit 6 enables sampling block
// RL6 - sampling enabled at entry fails entry
// RL7 - feature id bit 20 reads one
// RL8 - host mode uses and writes host copy
// RL9 - entry loads guest copy from block
// RL10 - ordinary guest uses OR of copies
// RL11 - guest writes touch only guest copy
// RL12 - exit stores guest copy, reverts host
// RL13 - isolated guest ignores host restrict bit
`timescale 1ns/100ps
`default_nettype none
module guest_speculation_control (
  input  wire logic                               clk,
  input  wire logic                               rst_b,
  // axi4-lite slave
  input  wire logic [7:0]                         s_axi_awaddr,
  input  wire logic                               s_axi_awvalid,
  output logic                                    s_axi_awready,
  input  wire logic [31:0]                        s_axi_wdata,
  input  wire logic [3:0]                         s_axi_wstrb,
  input  wire logic                               s_axi_wvalid,
  output logic                                    s_axi_wready,
  output logic [1:0]                              s_axi_bresp,
  output logic                                    s_axi_bvalid,
  input  wire logic                               s_axi_bready,
  input  wire logic [7:0]                         s_axi_araddr,
  input  wire logic                               s_axi_arvalid,
  output logic                                    s_axi_arready,
  output logic [31:0]                             s_axi_rdata,
  output logic [1:0]                              s_axi_rresp,
  output logic                                    s_axi_rvalid,
  input  wire logic                               s_axi_rready,
  // guest entry and exit
  input  wire logic                               guest_entry,
  input  wire logic                               guest_exit,
  input  wire logic [speculation_control_reg_pkg::FEAT_W-1:0]   guest_feature_mask,
  input  wire logic [31:0]                        block_spec_in,
  input  wire logic [speculation_control_reg_pkg::CTX_W-1:0]    guest_ctx,
  input  wire logic                               fetch_sampling_enable,
  input  wire logic                               op_sampling_enable,
  output logic                                    invalid_state_exit,
  output logic                                    block_spec_we,
  output logic [31:0]                             block_spec_out,
  // speculation controls and predictor training
  input  wire logic                               guest_spec_write,
  input  wire logic [31:0]                        guest_spec_wdata,
  output logic [31:0]                             effective_spec,
  input  wire logic                               pred_train,
  input  wire logic [speculation_control_reg_pkg::TABLE_AW-1:0] pred_addr,
  output logic                                    pred_write,
  output logic                                    table_flush,
  output logic                                    irq
);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  speculation_control_reg_pkg::mode_e                mode;
  speculation_control_reg_pkg::mode_e                next_mode;
  logic [31:0]                         host_spec;
  logic [31:0]                         next_host_spec;
  logic [31:0]                         guest_spec;
  logic [31:0]                         next_guest_spec;
  logic                                isolation;
  logic                                next_isolation;
  logic                                sampling_block;
  logic                                next_sampling_block;
  logic [speculation_control_reg_pkg::CTX_W-1:0]     cur_ctx;
  logic [speculation_control_reg_pkg::CTX_W-1:0]     next_cur_ctx;
  logic [speculation_control_reg_pkg::EV_W-1:0]      irq_status;
  logic [speculation_control_reg_pkg::EV_W-1:0]      next_irq_status;
  logic [speculation_control_reg_pkg::EV_W-1:0]      irq_mask;
  logic [speculation_control_reg_pkg::EV_W-1:0]      next_irq_mask;
  logic [speculation_control_reg_pkg::EV_W-1:0]      events;
  logic                                entry_ok;
  logic                                entry_bad;
  logic                                foreign_hit;
  logic                                tag_valid;
  logic [speculation_control_reg_pkg::CTX_W-1:0]     tag_ctx;
  logic                                aw_held;
  logic                                next_aw_held;
  logic [7:0]                          aw_addr;
  logic [7:0]                          next_aw_addr;
  logic                                w_held;
  logic                                next_w_held;
  logic [31:0]                         w_data;
  logic [31:0]                         next_w_data;
  logic [3:0]                          w_strb;
  logic [3:0]                          next_w_strb;
  logic                                next_bvalid;
  logic [1:0]                          next_bresp;
  logic                                next_rvalid;
  logic [31:0]                         next_rdata;
  logic [1:0]                          next_rresp;
  logic                                wr_fire;
  logic                                host_wr;

  function automatic logic [31:0] apply_strb(input logic [31:0] old, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction : apply_strb

  // ----------------------------------------
  // entry checks and effective controls
  // ----------------------------------------
  // RL6 sampling entry check
  assign entry_bad = guest_entry && (mode == speculation_control_reg_pkg::MODE_HOST)
                     && guest_feature_mask[speculation_control_reg_pkg::SAMPLING_BLOCK_BIT]
                     && (fetch_sampling_enable || op_sampling_enable);
  assign entry_ok  = guest_entry && (mode == speculation_control_reg_pkg::MODE_HOST) && !entry_bad;
  assign invalid_state_exit = entry_bad;

  always_comb begin
    // RL8 host copy only
    effective_spec = host_spec;
    if (mode == speculation_control_reg_pkg::MODE_GUEST) begin
      // RL10 ordinary guest OR
      effective_spec = host_spec | guest_spec;
      if (isolation) begin
        // RL13 guest restrict bit alone
        effective_spec[speculation_control_reg_pkg::RESTRICT_BIT] = guest_spec[speculation_control_reg_pkg::RESTRICT_BIT];
      end
    end
  end

  // RL3 restrict blocks training
  assign pred_write = pred_train && !effective_spec[speculation_control_reg_pkg::RESTRICT_BIT];

  // ----------------------------------------
  // predictor owner tracking
  // ----------------------------------------
  pred_tag_mem u_tags (
    .clk      (clk),
    .rst_b    (rst_b),
    .wr_en    (pred_write),
    .wr_addr  (pred_addr),
    .wr_ctx   (cur_ctx),
    .flush    (table_flush),
    .rd_addr  (pred_addr),
    .rd_valid (tag_valid),
    .rd_ctx   (tag_ctx)
  );

  // RL2 flush on foreign owner
  assign foreign_hit = (mode == speculation_control_reg_pkg::MODE_GUEST) && isolation && tag_valid
                       && (tag_ctx != cur_ctx);
  assign table_flush = foreign_hit || (entry_ok &&
                       guest_feature_mask[speculation_control_reg_pkg::ISOLATION_BIT] && guest_ctx != cur_ctx);

  // ----------------------------------------
  // mode and copies
  // ----------------------------------------
  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign host_wr = wr_fire && (aw_addr == speculation_control_reg_pkg::OFS_HOST_SPEC);

  always_comb begin
    next_mode           = mode;
    next_host_spec      = host_spec;
    next_guest_spec     = guest_spec;
    next_isolation      = isolation;
    next_sampling_block = sampling_block;
    next_cur_ctx        = cur_ctx;
    block_spec_we       = 1'b0;
    block_spec_out      = guest_spec;
    case (mode)
      speculation_control_reg_pkg::MODE_HOST: begin
        // RL8 host writes host copy
        if (host_wr) begin
          next_host_spec = apply_strb(host_spec, w_data, w_strb);
        end
        if (entry_ok) begin
          next_mode = speculation_control_reg_pkg::MODE_GUEST;
          // RL9 load guest copy
          next_guest_spec = block_spec_in;
          // RL1 isolation from feature mask
          next_isolation = guest_feature_mask[speculation_control_reg_pkg::ISOLATION_BIT];
          // RL5 sampling block from mask
          next_sampling_block = guest_feature_mask[speculation_control_reg_pkg::SAMPLING_BLOCK_BIT];
          next_cur_ctx = guest_ctx;
        end
      end
      speculation_control_reg_pkg::MODE_GUEST: begin
        // RL11 guest writes guest copy
        if (guest_spec_write) begin
          next_guest_spec = guest_spec_wdata;
        end
        if (guest_exit) begin
          // RL12 save and revert
          block_spec_we  = 1'b1;
          block_spec_out = guest_spec;
          next_mode      = speculation_control_reg_pkg::MODE_HOST;
          next_cur_ctx   = speculation_control_reg_pkg::RESET_CTX;
        end
      end
      default: begin
        next_mode = speculation_control_reg_pkg::MODE_HOST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode           <= speculation_control_reg_pkg::MODE_HOST;
      host_spec      <= speculation_control_reg_pkg::RESET_SPEC;
      guest_spec     <= speculation_control_reg_pkg::RESET_SPEC;
      isolation      <= 1'b0;
      sampling_block <= 1'b0;
      cur_ctx        <= speculation_control_reg_pkg::RESET_CTX;
    end else begin
      mode           <= next_mode;
      host_spec      <= next_host_spec;
      guest_spec     <= next_guest_spec;
      isolation      <= next_isolation;
      sampling_block <= next_sampling_block;
      cur_ctx        <= next_cur_ctx;
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  assign events = {table_flush, entry_bad, guest_exit && mode == speculation_control_reg_pkg::MODE_GUEST,
                   entry_ok};

  always_comb begin
    next_irq_mask   = irq_mask;
    next_irq_status = irq_status;
    if (wr_fire && aw_addr == speculation_control_reg_pkg::OFS_IRQ_MASK) begin
      next_irq_mask = w_data[speculation_control_reg_pkg::EV_W-1:0];
    end
    if (wr_fire && aw_addr == speculation_control_reg_pkg::OFS_IRQ_STATUS) begin
      next_irq_status = irq_status & ~w_data[speculation_control_reg_pkg::EV_W-1:0];
    end
    // set wins over a clear in the same cycle
    next_irq_status = next_irq_status | events;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      irq_status <= '0;
      irq_mask   <= '0;
    end else begin
      irq_status <= next_irq_status;
      irq_mask   <= next_irq_mask;
    end
  end

  assign irq = |(irq_status & irq_mask);

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      if (aw_addr == speculation_control_reg_pkg::OFS_HOST_SPEC || aw_addr == speculation_control_reg_pkg::OFS_IRQ_STATUS
          || aw_addr == speculation_control_reg_pkg::OFS_IRQ_MASK) begin
        next_bresp = RESP_OKAY;
      end else begin
        next_bresp = RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && !s_axi_rvalid) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = '0;
      if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_HOST_SPEC[7:2]) begin
        next_rdata = host_spec;
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_GUEST_SPEC[7:2]) begin
        next_rdata = guest_spec;
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_EFFECTIVE[7:2]) begin
        next_rdata = effective_spec;
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_STATUS[7:2]) begin
        next_rdata = {29'h0000_0000, sampling_block, isolation, mode == speculation_control_reg_pkg::MODE_GUEST};
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_IRQ_STATUS[7:2]) begin
        next_rdata = {28'h000_0000, irq_status};
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_IRQ_MASK[7:2]) begin
        next_rdata = {28'h000_0000, irq_mask};
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_FEATURE_ID[7:2]) begin
        // RL7 feature id bit
        next_rdata[speculation_control_reg_pkg::FEATURE_ID_BIT] = 1'b1;
      end else if (s_axi_araddr[7:2] == speculation_control_reg_pkg::OFS_CONTEXT[7:2]) begin
        next_rdata = {28'h000_0000, cur_ctx};
      end else begin
        next_rresp = RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held      <= 1'b0;
      aw_addr      <= 8'h00;
      w_held       <= 1'b0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      aw_held      <= next_aw_held;
      aw_addr      <= next_aw_addr;
      w_held       <= next_w_held;
      w_data       <= next_w_data;
      w_strb       <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_entry;
    entry_ok && guest_feature_mask[speculation_control_reg_pkg::ISOLATION_BIT];
  endsequence

  chk_isolation_set: assert property (@(posedge clk) disable iff (!rst_b) // RL1
    s_entry |=> isolation) else $error("isolation not set on entry");
  chk_foreign_flush: assert property (@(posedge clk) disable iff (!rst_b) // RL2
    foreign_hit |-> table_flush ##2 !tag_valid) else $error("foreign entry not flushed");
  chk_restrict_write: assert property (@(posedge clk) disable iff (!rst_b) // RL3
    effective_spec[speculation_control_reg_pkg::RESTRICT_BIT] |-> !pred_write)
    else $error("table written while restricted");
  chk_block_latch: assert property (@(posedge clk) disable iff (!rst_b) // RL5
    entry_ok |=> sampling_block == $past(guest_feature_mask[speculation_control_reg_pkg::SAMPLING_BLOCK_BIT]))
    else $error("sampling block not latched");
  chk_entry_refused: assert property (@(posedge clk) disable iff (!rst_b) // RL6
    entry_bad |=> mode == speculation_control_reg_pkg::MODE_HOST && irq_status[speculation_control_reg_pkg::EV_INVALID])
    else $error("bad entry not refused");
  chk_host_only: assert property (@(posedge clk) disable iff (!rst_b) // RL8
    mode == speculation_control_reg_pkg::MODE_HOST |-> effective_spec == host_spec)
    else $error("host mode not host copy");
  chk_guest_load: assert property (@(posedge clk) disable iff (!rst_b) // RL9
    entry_ok |=> guest_spec == $past(block_spec_in)) else $error("guest copy not loaded");
  chk_guest_write: assert property (@(posedge clk) disable iff (!rst_b) // RL11
    mode == speculation_control_reg_pkg::MODE_GUEST && guest_spec_write |=> host_spec == $past(host_spec))
    else $error("guest write changed host copy");
  chk_exit_save: assert property (@(posedge clk) disable iff (!rst_b) // RL12
    mode == speculation_control_reg_pkg::MODE_GUEST && guest_exit |-> block_spec_we ##1
    mode == speculation_control_reg_pkg::MODE_HOST) else $error("exit not saved");
  chk_isolated_restrict: assert property (@(posedge clk) disable iff (!rst_b) // RL13
    mode == speculation_control_reg_pkg::MODE_GUEST && isolation |->
    effective_spec[speculation_control_reg_pkg::RESTRICT_BIT] == guest_spec[speculation_control_reg_pkg::RESTRICT_BIT])
    else $error("host restrict overrode guest");
endmodule : guest_speculation_control
`default_nettype wire

// ===== test/guest_speculation_control_reg_test.sv
// self-checking bench for the guest speculation control block
`timescale 1ns/100ps
`default_nettype none
module guest_speculation_control_test;
  logic        clk, rst_b, awvalid, wvalid, arvalid, entry, gexit, fse, ose, gsw, train;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, bsin, gswd, seed, host_m, guest_m, d;
  logic [63:0] fmask;
  logic [3:0]  ctx, paddr;
  logic [1:0]  r;
  logic        mode_m, iso_m, inv, fl;
  wire  logic        awready, wready, bvalid, arready, rvalid, inv_exit, bwe, pwr, tflush, irq;
  wire  logic [1:0]  bresp, rresp;
  wire  logic [31:0] rdata, bsout, eff;
  logic [31:0] exp_q[$];
  int          failures, checks_done;

  guest_speculation_control dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .guest_entry(entry), .guest_exit(gexit), .guest_feature_mask(fmask), .block_spec_in(bsin),
    .guest_ctx(ctx), .fetch_sampling_enable(fse), .op_sampling_enable(ose),
    .invalid_state_exit(inv_exit), .block_spec_we(bwe), .block_spec_out(bsout),
    .guest_spec_write(gsw), .guest_spec_wdata(gswd), .effective_spec(eff), .pred_train(train),
    .pred_addr(paddr), .pred_write(pwr), .table_flush(tflush), .irq(irq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // model of the applied controls: isolation keeps the guest restrict bit alone
  function automatic logic [31:0] eff_m();
    if (!mode_m) return host_m;
    if (iso_m) return ((host_m | guest_m) & ~32'h1) | (guest_m & 32'h1);
    return host_m | guest_m;
  endfunction : eff_m

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic test_done();
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done

  task automatic axw(input logic [7:0] a, input logic [31:0] v);
    logic ta, tw, tb;
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r  = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : axw

  task automatic axr(input logic [7:0] a);
    logic ta, tr;
    araddr  <= a;
    arvalid <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      #1;
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : axr

  task automatic enter(input logic [63:0] fm, input logic [31:0] gs, input logic [3:0] c,
                       input logic f, input logic o);
    fmask <= fm;
    bsin  <= gs;
    ctx   <= c;
    fse   <= f;
    ose   <= o;
    entry <= 1'b1;
    #1;
    inv = inv_exit;
    fl  = tflush;
    @(posedge clk);
    entry <= 1'b0;
    #1;
    fl = fl | tflush;
    @(posedge clk);
  endtask : enter

  task automatic leave();
    gexit <= 1'b1;
    #1;
    chk("store_we", 1, bwe);
    chk("store_data", exp_q.pop_front(), bsout);
    @(posedge clk);
    gexit <= 1'b0;
    mode_m = 1'b0;
    @(posedge clk);
    axr(8'h08);
    chk("eff_after_exit", eff_m(), d);
  endtask : leave

  task automatic train_chk();
    train <= 1'b1;
    paddr <= 4'(rnd());
    #1;
    chk("eff_port", eff_m(), eff);
    chk("pred_write", ~eff_m() & 32'h1, pwr);
    @(posedge clk);
    train <= 1'b0;
  endtask : train_chk

  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    test_done();
  end

  initial begin
    {rst_b, awvalid, wvalid, arvalid, entry, gexit, fse, ose, gsw, train} = '0;
    {awaddr, araddr, wdata, bsin, gswd, fmask, ctx, paddr} = '0;
    {failures, checks_done, mode_m, iso_m} = '0;
    seed = 32'h913bc057;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    axr(8'h18);
    chk("feature_id", 1, d[speculation_control_reg_pkg::FEATURE_ID_BIT]);
    axr(8'h08);
    chk("eff_reset", 0, d);
    // hosts between guest runs keep restrict set
    host_m = rnd() | 32'h1;
    axw(8'h00, host_m);
    chk("host_wr_resp", 0, r);
    axr(8'h08);
    chk("eff_host", eff_m(), d);
    axw(8'h04, rnd());
    chk("ro_wr_resp", 2, r);
    axr(8'h40);
    chk("unmapped_resp", 2, r);
    train_chk();
    for (int i = 3; i >= 0; i--) begin
      guest_m = rnd();
      enter(64'h40, guest_m, 4'h0, i[1], i[0]);
      chk("invalid_exit", i != 0, inv);
      axr(8'h0C);
      chk("status", (i != 0) ? 0 : 32'h5, d);
    end
    mode_m = 1'b1;
    exp_q.push_back(guest_m);
    axr(8'h04);
    chk("guest_loaded", guest_m, d);
    axr(8'h08);
    chk("eff_or", eff_m(), d);
    train_chk();
    guest_m = rnd();
    gsw  <= 1'b1;
    gswd <= guest_m;
    @(posedge clk);
    gsw <= 1'b0;
    exp_q[0] = guest_m;
    @(posedge clk);
    axr(8'h00);
    chk("host_kept", host_m, d);
    axr(8'h08);
    chk("eff_guest_wr", eff_m(), d);
    leave();
    guest_m = rnd() & ~32'h1;
    enter(64'h80, guest_m, 4'h5, 1'b1, 1'b1);
    mode_m = 1'b1;
    iso_m  = 1'b1;
    exp_q.push_back(guest_m);
    chk("iso_entry_ok", 0, inv);
    chk("iso_flush", 1, fl);
    axr(8'h0C);
    chk("iso_status", 32'h3, d);
    axr(8'h08);
    chk("eff_iso", eff_m(), d);
    train_chk();
    leave();
    // the entry trained above belongs to context 5; an isolated guest 0 must drop it
    guest_m = rnd() & ~32'h1;
    enter(64'h80, guest_m, 4'h0, 1'b0, 1'b0);
    mode_m = 1'b1;
    exp_q.push_back(guest_m);
    chk("foreign_flush", 1, fl);
    leave();
    axr(8'h10);
    chk("irq_status", 32'hF, d);
    axw(8'h14, 32'h0);
    chk("irq_masked", 0, irq);
    axw(8'h14, 32'h2);
    chk("irq_on", 1, irq);
    axw(8'h10, 32'hF);
    chk("irq_clr", 0, irq);
    axr(8'h10);
    chk("status_clr", 0, d);
    test_done();
  end
endmodule : guest_speculation_control_test
`default_nettype wire
